// ==== src/uaem_pkg.sv ====
// Purpose: Shared constants for the alarm and event monitor
// Assumes: 16-bit record words, one system clock
// Notes: Record addresses are the word addresses seen by the record reader
package uaem_pkg;
	localparam int unsigned DW = 16;
	localparam int unsigned AW = 16;

	// Record addresses
	localparam logic [15:0] ADR_IN_UV = 16'h4031;
	localparam logic [15:0] ADR_IN_OV = 16'h4032;
	localparam logic [15:0] ADR_OUT_UV = 16'h4033;
	localparam logic [15:0] ADR_OUT_OV = 16'h4034;
	localparam logic [15:0] ADR_OUT_OVL = 16'h4035;
	localparam logic [15:0] ADR_IN_OC = 16'h4036;
	localparam logic [15:0] ADR_AUX_OVL = 16'h4037;
	localparam logic [15:0] ADR_SENS_ERR = 16'h4038;
	localparam logic [15:0] ADR_BT_LOW = 16'h4039;
	localparam logic [15:0] ADR_OT_WARN = 16'h403a;
	localparam logic [15:0] ADR_OT_ERR = 16'h403b;
	localparam logic [15:0] ADR_PWR_ON = 16'he000;
	localparam logic [15:0] ADR_SHUTDN = 16'he001;

	// Voltage limits as ratios of nominal output voltage
	localparam logic [19:0] LIM_LO_NUM = 20'h00009;
	localparam logic [19:0] LIM_HI_NUM = 20'h0000c;
	localparam logic [19:0] LIM_DEN = 20'h0000a;

	// Alarm record first value
	localparam logic [15:0] ST_INACTIVE = 16'h0000;
	localparam logic [15:0] ST_ACTIVE = 16'h0001;
	localparam logic [15:0] VAL_UNUSED = 16'h0000;

	// Shutdown reason codes
	localparam logic [2:0] RSN_DEEP_DIS = 3'h1;
	localparam logic [2:0] RSN_BT_ELAPSED = 3'h2;
	localparam logic [2:0] RSN_SD_CMD = 3'h3;
	localparam logic [2:0] RSN_RST_CMD = 3'h4;
	localparam logic [2:0] RSN_INHIBIT = 3'h5;

	// Reset values
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [2:0] RSN_RST = 3'h0;
endpackage : uaem_pkg

// ==== src/uaem_volt_track.sv ====
// Purpose: One voltage alarm with limit and extreme capture
// Assumes: upd is a one-cycle pulse from same-clock measurement logic
// Notes: OVER=1 trips above the limit and keeps the maximum, else below and minimum
module uaem_volt_track #(
	parameter bit OVER = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic upd,
	input wire logic [15:0] meas,
	input wire logic [15:0] limit,
	output logic active_ff,
	output logic [15:0] val2_ff
);
	logic cond;
	logic [15:0] ext_ff;
	logic [15:0] nxt_ext;

	assign cond = OVER ? (meas > limit) : (meas < limit);

	always_comb begin
		nxt_ext = ext_ff;
		if (OVER && meas > ext_ff) begin
			nxt_ext = meas;
		end else if (!OVER && meas < ext_ff) begin
			nxt_ext = meas;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			active_ff <= 1'b0;
			val2_ff <= uaem_pkg::VAL_UNUSED;
			ext_ff <= uaem_pkg::VAL_UNUSED;
		end else if (upd) begin
			if (!active_ff && cond) begin
				active_ff <= 1'b1;
				val2_ff <= limit;
				ext_ff <= meas;
			end else if (active_ff && cond) begin
				ext_ff <= nxt_ext;
			end else if (active_ff && !cond) begin
				// Reading that ends the alarm is outside the active period
				active_ff <= 1'b0;
				val2_ff <= ext_ff;
			end
		end
	end

	sequence trip_s;
		upd && !active_ff && cond;
	endsequence

	sequence clear_s;
		upd && active_ff && !cond;
	endsequence

	trip_limit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		trip_s |=> active_ff && val2_ff == $past(limit))
		else $error("limit not captured on alarm entry");

	clear_ext_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clear_s |=> !active_ff && val2_ff == $past(ext_ff))
		else $error("extreme not reported on alarm exit");

	ext_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		upd && active_ff && cond |=>
			(OVER ? ext_ff >= $past(meas) : ext_ff <= $past(meas)))
		else $error("extreme tracking in wrong direction");
endmodule : uaem_volt_track

// ==== src/uaem_monitor.sv ====
// Purpose: Alarm and event monitor of the supply module, read as 16-bit records
// Assumes: Measurements and limits come from same-clock logic, refreshed by meas_upd
// Notes: Aux overload and sensor presence are pins and are synchronised
// Functional notes
// - Input undervoltage below 90% of nominal
// - Input overvoltage above 120% of nominal
// - Output undervoltage below 90% of nominal
// - Output overvoltage above 120% of nominal
// - First value: 0 inactive, 1 active
// - Voltage alarm entry captures crossed limit
// - Overvoltage exit reports maximum measured voltage
// - Undervoltage exit reports minimum measured voltage
// - Output overload when current reaches maximum
// - Input overcurrent when current reaches maximum
// - Aux overload on excessive auxiliary load
// - Sensor error when required sensor absent
// - Low backup time only while in backup
// - Overtemperature warning when temperature high
// - Overtemperature error switches device off
// - Power-on event counts every turn-on
// - Shutdown event counts turn-offs, keeps reason
module uaem_monitor (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic meas_upd,
	input wire logic [15:0] vin_meas,
	input wire logic [15:0] vout_meas,
	input wire logic [15:0] iin_meas,
	input wire logic [15:0] iout_meas,
	input wire logic [15:0] temp_meas,
	input wire logic [15:0] backup_left,
	input wire logic in_backup,
	input wire logic [15:0] nom_vout_cfg,
	input wire logic [15:0] max_iout_cfg,
	input wire logic [15:0] max_iin_cfg,
	input wire logic [15:0] max_backup_cfg,
	input wire logic [15:0] temp_warn_cfg,
	input wire logic [15:0] temp_err_cfg,
	input wire logic sensor_required,
	input wire logic aux_overload_pin,
	input wire logic ext_sensor_present_pin,
	input wire logic turn_on,
	input wire logic turn_off,
	input wire logic [2:0] off_reason,
	input wire logic rd_req,
	input wire logic [15:0] rd_addr,
	output logic rd_valid_ff,
	output logic rd_err_ff,
	output logic [15:0] rd_val1_ff,
	output logic [15:0] rd_val2_ff,
	output logic switch_off_ff
);
	logic [19:0] prod_lo;
	logic [19:0] prod_hi;
	logic [15:0] lim_lo;
	logic [15:0] lim_hi;
	logic [1:0] aux_sync_ff;
	logic [1:0] sens_sync_ff;
	logic in_uv;
	logic in_ov;
	logic out_uv;
	logic out_ov;
	logic [15:0] in_uv_v2;
	logic [15:0] in_ov_v2;
	logic [15:0] out_uv_v2;
	logic [15:0] out_ov_v2;
	logic out_ovl_ff;
	logic in_oc_ff;
	logic aux_ovl_ff;
	logic sens_err_ff;
	logic bt_low_ff;
	logic ot_warn_ff;
	logic ot_err_ff;
	logic [15:0] pwr_on_cnt_ff;
	logic [15:0] shutdn_cnt_ff;
	logic [2:0] shutdn_rsn_ff;
	logic nxt_err;
	logic [15:0] nxt_val1;
	logic [15:0] nxt_val2;

	// Limits derived from nominal output voltage; widened so the product cannot wrap
	assign prod_lo = ({4'h0, nom_vout_cfg} * uaem_pkg::LIM_LO_NUM) / uaem_pkg::LIM_DEN;
	assign prod_hi = ({4'h0, nom_vout_cfg} * uaem_pkg::LIM_HI_NUM) / uaem_pkg::LIM_DEN;
	assign lim_lo = prod_lo[15:0];
	// 120% of a nominal near full scale saturates rather than wrapping low
	assign lim_hi = (prod_hi[19:16] != 4'h0) ? 16'hffff : prod_hi[15:0];

	// Pin synchronisers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aux_sync_ff <= 2'h0;
			sens_sync_ff <= 2'h0;
		end else begin
			aux_sync_ff <= {aux_sync_ff[0], aux_overload_pin};
			sens_sync_ff <= {sens_sync_ff[0], ext_sensor_present_pin};
		end
	end

	uaem_volt_track #(.OVER(1'b0)) u_in_uv (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.upd(meas_upd),
		.meas(vin_meas),
		.limit(lim_lo),
		.active_ff(in_uv),
		.val2_ff(in_uv_v2)
	);

	uaem_volt_track #(.OVER(1'b1)) u_in_ov (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.upd(meas_upd),
		.meas(vin_meas),
		.limit(lim_hi),
		.active_ff(in_ov),
		.val2_ff(in_ov_v2)
	);

	uaem_volt_track #(.OVER(1'b0)) u_out_uv (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.upd(meas_upd),
		.meas(vout_meas),
		.limit(lim_lo),
		.active_ff(out_uv),
		.val2_ff(out_uv_v2)
	);

	uaem_volt_track #(.OVER(1'b1)) u_out_ov (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.upd(meas_upd),
		.meas(vout_meas),
		.limit(lim_hi),
		.active_ff(out_ov),
		.val2_ff(out_ov_v2)
	);

	// Plain alarms only move on an update, so a read never sees a half-applied set
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_ovl_ff <= 1'b0;
			in_oc_ff <= 1'b0;
			aux_ovl_ff <= 1'b0;
			sens_err_ff <= 1'b0;
			bt_low_ff <= 1'b0;
			ot_warn_ff <= 1'b0;
			ot_err_ff <= 1'b0;
		end else if (meas_upd) begin
			out_ovl_ff <= iout_meas >= max_iout_cfg;
			in_oc_ff <= iin_meas >= max_iin_cfg;
			aux_ovl_ff <= aux_sync_ff[1];
			sens_err_ff <= sensor_required && !sens_sync_ff[1];
			bt_low_ff <= in_backup && (backup_left < max_backup_cfg);
			ot_warn_ff <= temp_meas > temp_warn_cfg;
			ot_err_ff <= temp_meas > temp_err_cfg;
		end
	end

	// Thermal switch-off latches until a turn-on while ot_err_ff is clear; a set ot_err_ff wins over turn_on
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			switch_off_ff <= 1'b0;
		end else if (ot_err_ff) begin
			switch_off_ff <= 1'b1;
		end else if (turn_on) begin
			switch_off_ff <= 1'b0;
		end
	end

	// Event records; counters wrap at 16 bits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwr_on_cnt_ff <= uaem_pkg::CNT_RST;
		end else if (turn_on) begin
			pwr_on_cnt_ff <= pwr_on_cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shutdn_cnt_ff <= uaem_pkg::CNT_RST;
			shutdn_rsn_ff <= uaem_pkg::RSN_RST;
		end else if (turn_off) begin
			shutdn_cnt_ff <= shutdn_cnt_ff + 16'h0001;
			shutdn_rsn_ff <= off_reason;
		end
	end

	function automatic logic [15:0] st_word(input logic flag);
		st_word = flag ? uaem_pkg::ST_ACTIVE : uaem_pkg::ST_INACTIVE;
	endfunction : st_word

	// Record read decode
	always_comb begin
		nxt_err = 1'b0;
		nxt_val1 = uaem_pkg::VAL_UNUSED;
		nxt_val2 = uaem_pkg::VAL_UNUSED;
		case (rd_addr)
			uaem_pkg::ADR_IN_UV: begin
				nxt_val1 = st_word(in_uv);
				nxt_val2 = in_uv_v2;
			end
			uaem_pkg::ADR_IN_OV: begin
				nxt_val1 = st_word(in_ov);
				nxt_val2 = in_ov_v2;
			end
			uaem_pkg::ADR_OUT_UV: begin
				nxt_val1 = st_word(out_uv);
				nxt_val2 = out_uv_v2;
			end
			uaem_pkg::ADR_OUT_OV: begin
				nxt_val1 = st_word(out_ov);
				nxt_val2 = out_ov_v2;
			end
			uaem_pkg::ADR_OUT_OVL: nxt_val1 = st_word(out_ovl_ff);
			uaem_pkg::ADR_IN_OC: nxt_val1 = st_word(in_oc_ff);
			uaem_pkg::ADR_AUX_OVL: nxt_val1 = st_word(aux_ovl_ff);
			uaem_pkg::ADR_SENS_ERR: nxt_val1 = st_word(sens_err_ff);
			uaem_pkg::ADR_BT_LOW: nxt_val1 = st_word(bt_low_ff);
			uaem_pkg::ADR_OT_WARN: nxt_val1 = st_word(ot_warn_ff);
			uaem_pkg::ADR_OT_ERR: nxt_val1 = st_word(ot_err_ff);
			uaem_pkg::ADR_PWR_ON: nxt_val1 = pwr_on_cnt_ff;
			uaem_pkg::ADR_SHUTDN: begin
				nxt_val1 = shutdn_cnt_ff;
				nxt_val2 = {13'h0000, shutdn_rsn_ff};
			end
			default: nxt_err = 1'b1;
		endcase
	end

	// Answer one cycle after the request; data holds until the next request
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid_ff <= 1'b0;
			rd_err_ff <= 1'b0;
			rd_val1_ff <= uaem_pkg::VAL_UNUSED;
			rd_val2_ff <= uaem_pkg::VAL_UNUSED;
		end else begin
			rd_valid_ff <= rd_req;
			if (rd_req) begin
				rd_err_ff <= nxt_err;
				rd_val1_ff <= nxt_val1;
				rd_val2_ff <= nxt_val2;
			end
		end
	end

	sequence upd_low_s;
		meas_upd && vin_meas < lim_lo;
	endsequence

	in_uv_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		upd_low_s |=> in_uv)
		else $error("input undervoltage not raised");

	in_ov_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && vin_meas > lim_hi |=> in_ov)
		else $error("input overvoltage not raised");

	out_uv_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && vout_meas >= lim_lo |=> !out_uv)
		else $error("output undervoltage raised in range");

	out_ov_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && vout_meas <= lim_hi |=> !out_ov)
		else $error("output overvoltage raised in range");

	rec_state_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_req && rd_addr == uaem_pkg::ADR_OUT_OVL |=>
			rd_valid_ff && rd_val1_ff == {15'h0000, $past(out_ovl_ff)})
		else $error("alarm state word wrong");

	ovl_reach_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && iout_meas == max_iout_cfg |=> out_ovl_ff)
		else $error("overload not raised at limit");

	oc_reach_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && iin_meas < max_iin_cfg |=> !in_oc_ff)
		else $error("overcurrent raised below limit");

	aux_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd |=> aux_ovl_ff == $past(aux_sync_ff[1]))
		else $error("aux overload not from synchronised pin");

	sens_err_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && !sensor_required |=> !sens_err_ff)
		else $error("sensor error while not required");

	bt_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && !in_backup |=> !bt_low_ff)
		else $error("backup time alarm outside backup");

	ot_warn_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && temp_meas > temp_warn_cfg |=> ot_warn_ff)
		else $error("overtemperature warning missing");

	ot_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		meas_upd && temp_meas > temp_err_cfg |=> ##1 switch_off_ff)
		else $error("no switch-off on overtemperature error");

	pwr_cnt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		turn_on |=> pwr_on_cnt_ff == $past(pwr_on_cnt_ff) + 16'h0001)
		else $error("power-on count not advanced");

	shutdn_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		turn_off |=> shutdn_rsn_ff == $past(off_reason)
			&& shutdn_cnt_ff == $past(shutdn_cnt_ff) + 16'h0001)
		else $error("shutdown record not updated");

	hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!meas_upd |=> $stable(ot_warn_ff) && $stable(bt_low_ff) && $stable(in_oc_ff))
		else $error("alarm moved without update");

	// Addresses outside the whole record span must come back flagged and empty
	unmapped_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_req && (rd_addr < uaem_pkg::ADR_IN_UV || rd_addr > uaem_pkg::ADR_SHUTDN) |=>
			rd_valid_ff && rd_err_ff && rd_val1_ff == uaem_pkg::VAL_UNUSED
			&& rd_val2_ff == uaem_pkg::VAL_UNUSED)
		else $error("unmapped record not flagged");
endmodule : uaem_monitor

// ==== tb/uaem_reader.sv ====
// Purpose: Record reader model standing in for the bus master
// Assumes: One read pulse per request, answer within three cycles
// Notes: Idle address shows its inverse so stale values never match
module uaem_reader (
	input wire logic clk_sys,
	output logic rd_req,
	output logic [15:0] rd_addr,
	input wire logic rd_valid_ff,
	input wire logic rd_err_ff,
	input wire logic [15:0] rd_val1_ff,
	input wire logic [15:0] rd_val2_ff
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		rd_req = 1'b0;
		rd_addr = 16'h0000;
	end

	// Idle cycles before the request let a read arrive slowly as well as promptly
	task automatic rd(input logic [15:0] a, input int idle, output logic [15:0] v1,
		output logic [15:0] v2, output logic e, output logic ok);
		{ok, e, v1, v2} = '0;
		repeat (idle + 1) @(posedge clk_sys);
		#1;
		rd_req = 1'b1;
		rd_addr = a;
		@(posedge clk_sys);
		#1;
		rd_req = 1'b0;
		rd_addr = ~a;
		for (int n = 0; n < 3 && !ok; n++) begin
			if (rd_valid_ff === 1'b1)
				{ok, e, v1, v2} = {1'b1, rd_err_ff, rd_val1_ff, rd_val2_ff};
			else
				@(posedge clk_sys) #1;
		end
	endtask : rd
endmodule : uaem_reader

// ==== tb/tb_uaem_monitor.sv ====
// Purpose: Self-checking bench for the alarm and event monitor
// Assumes: Reader model issues one record read at a time
// Notes: Nominal 1000 first, then 1005 so truncated limits show
module tb_uaem_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic meas_upd = 1'b0;
	logic [15:0] vin_meas, vout_meas, iin_meas, iout_meas, temp_meas, backup_left;
	logic in_backup, sensor_required, aux_overload_pin, ext_sensor_present_pin;
	logic turn_on, turn_off, rd_req, rd_valid_ff, rd_err_ff, switch_off_ff;
	logic [2:0] off_reason;
	logic [15:0] nom_vout_cfg, max_iout_cfg, max_iin_cfg, max_backup_cfg;
	logic [15:0] temp_warn_cfg, temp_err_cfg, rd_addr, rd_val1_ff, rd_val2_ff;
	int mismatches = 0;
	int check_count = 0;
	// vin vout iin iout temp backup {in_backup,required,aux,present} alarm mask
	logic [15:0] rows [5][8] = '{
		'{16'h03e8, 16'h03e8, 16'h0000, 16'h0000, 16'h0014, 16'h00c8, 16'h0001, 16'h0000},
		'{16'h0383, 16'h04b1, 16'h018f, 16'h01f4, 16'h0050, 16'h0063, 16'h0009, 16'h0119},
		'{16'h04b1, 16'h0383, 16'h0190, 16'h01f3, 16'h0051, 16'h0063, 16'h0006, 16'h02e6},
		'{16'h0384, 16'h04b0, 16'h0000, 16'h0000, 16'h0065, 16'h00c8, 16'h0001, 16'h0600},
		'{16'h03e8, 16'h03e8, 16'h0000, 16'h0000, 16'h0014, 16'h00c8, 16'h0001, 16'h0000}};
	logic [15:0] slo [5] = '{16'h0388, 16'h0387, 16'h0352, 16'h0370, 16'h03ed};
	logic [15:0] shi [5] = '{16'h04b6, 16'h04b7, 16'h0514, 16'h04e2, 16'h03ed};
	logic [15:0] elo [5] = '{16'h0000, 16'h0388, 16'h0388, 16'h0388, 16'h0352};
	logic [15:0] ehi [5] = '{16'h0000, 16'h04b6, 16'h04b6, 16'h04b6, 16'h0514};
	logic [4:0] act = 5'h0e;
	logic [15:0] bad [3] = '{16'h4030, 16'h403c, 16'he002};

	uaem_monitor u_uaem_monitor (.clk_sys, .rst_n, .meas_upd, .vin_meas, .vout_meas,
		.iin_meas, .iout_meas, .temp_meas, .backup_left, .in_backup, .nom_vout_cfg,
		.max_iout_cfg, .max_iin_cfg, .max_backup_cfg, .temp_warn_cfg, .temp_err_cfg,
		.sensor_required, .aux_overload_pin, .ext_sensor_present_pin, .turn_on, .turn_off,
		.off_reason, .rd_req, .rd_addr, .rd_valid_ff, .rd_err_ff, .rd_val1_ff, .rd_val2_ff,
		.switch_off_ff);

	uaem_reader u_uaem_reader (.clk_sys, .rd_req, .rd_addr, .rd_valid_ff, .rd_err_ff,
		.rd_val1_ff, .rd_val2_ff);

	always #50 clk_sys = ~clk_sys;

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rdc(input logic [15:0] a, output logic [15:0] v1, v2, output logic e);
		logic ok;
		u_uaem_reader.rd(a, int'(a[1:0]), v1, v2, e, ok);
		chk("read answer", 16'h0001, {15'h0000, ok});
	endtask : rdc

	// Three edges of settling first so synchronised pins reach the update
	task automatic upd(input logic [15:0] vi, vo, ii, io, t, bl, input logic [3:0] c);
		@(posedge clk_sys);
		#1;
		{vin_meas, vout_meas, iin_meas, iout_meas, temp_meas, backup_left} = {vi, vo, ii, io, t, bl};
		{in_backup, sensor_required, aux_overload_pin, ext_sensor_present_pin} = c;
		repeat (3) @(posedge clk_sys);
		#1 meas_upd = 1'b1;
		@(posedge clk_sys);
		#1 meas_upd = 1'b0;
	endtask : upd

	task automatic ev(input logic on, input logic [2:0] rsn);
		@(posedge clk_sys);
		#1;
		{turn_on, turn_off, off_reason} = {on, !on, rsn};
		@(posedge clk_sys);
		#1;
		{turn_on, turn_off, off_reason} = {2'b00, ~rsn};
	endtask : ev

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	// Whole run is under a thousand cycles; twenty thousand means a hang
	initial begin
		#2000000;
		mismatches++;
		final_report();
	end

	initial begin
		logic [15:0] v1, v2, x;
		logic e;
		{vin_meas, vout_meas, iin_meas, iout_meas, temp_meas, backup_left} = '0;
		{in_backup, sensor_required, aux_overload_pin, ext_sensor_present_pin} = 4'h1;
		{turn_on, turn_off, off_reason} = 5'h00;
		{nom_vout_cfg, max_iout_cfg, max_iin_cfg} = {16'h03e8, 16'h01f4, 16'h0190};
		{max_backup_cfg, temp_warn_cfg, temp_err_cfg} = {16'h0064, 16'h0050, 16'h0064};
		repeat (3) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		for (int r = 0; r < 5; r++) begin
			upd(rows[r][0], rows[r][1], rows[r][2], rows[r][3], rows[r][4], rows[r][5], rows[r][6][3:0]);
			for (int i = 0; i < 11; i++) begin
				rdc(16'h4031 + 16'(i), v1, v2, e);
				x = {15'h0000, rows[r][7][i]};
				if (i < 4) chk("state", x, v1);
				else chk("state", x, v1);
				if (i > 3) chk("unused value", 16'h0000, v2);
			end
			if (r == 3) chk("switch off", 16'h0001, {15'h0000, switch_off_ff});
		end
		@(posedge clk_sys);
		#1 vin_meas = 16'h0000;
		rdc(16'h4031, v1, v2, e);
		chk("held state", 16'h0000, v1);
		nom_vout_cfg = 16'h03ed;
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 5; i++) begin
				upd(k ? shi[i] : slo[i], k ? slo[i] : shi[i], 16'h0000, 16'h0000, 16'h0014,
					16'h00c8, 4'h1);
				rdc(k ? 16'h4033 : 16'h4031, v1, v2, e);
				chk("under state", {15'h0000, act[i]}, v1);
				if (i > 0) chk("under value", elo[i], v2);
				rdc(k ? 16'h4032 : 16'h4034, v1, v2, e);
				chk("over state", {15'h0000, act[i]}, v1);
				if (i > 0) chk("over value", ehi[i], v2);
			end
		end
		ev(1'b1, 3'h0);
		chk("switch off", 16'h0000, {15'h0000, switch_off_ff});
		rdc(16'he000, v1, v2, e);
		chk("power on count", 16'h0001, v1);
		chk("power on value", 16'h0000, v2);
		for (int k = 1; k < 6; k++) begin
			ev(1'b0, 3'(k));
			rdc(16'he001, v1, v2, e);
			chk("shutdown count", 16'(k), v1);
			chk("shutdown reason", 16'(k), v2);
		end
		for (int k = 0; k < 3; k++) begin
			rdc(bad[k], v1, v2, e);
			chk("unmapped flag", 16'h0001, {15'h0000, e});
			chk("unmapped value", 16'h0000, v1 | v2);
		end
		@(posedge clk_sys);
		#1 rst_n = 1'b0;
		#1 chk("reset outputs", 16'h0000, {rd_valid_ff, rd_err_ff, switch_off_ff, 13'h0000});
		repeat (3) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		for (int k = 0; k < 13; k++) begin
			rdc(k < 11 ? 16'h4031 + 16'(k) : 16'he000 + 16'(k - 11), v1, v2, e);
			chk("reset record", 16'h0000, v1 | v2 | {15'h0000, e});
		end
		final_report();
	end
endmodule : tb_uaem_monitor
